// ### logic/bcfsc_pkg.sv
// bcfsc_pkg: constants for the bus clock and fail-safe control block
// assumes a 50 MHz ref_clk and the plain register port of bcfsc_top
`default_nettype none
package bcfsc_pkg;
    // register indices on the plain register port
    localparam logic [3:0] OSC_CTRL_ADDR    = 4'h0;
    localparam logic [3:0] IRQ_FLAG_ADDR    = 4'h1;
    localparam logic [3:0] IRQ_EN_ADDR      = 4'h2;
    localparam logic [3:0] IRQ_PRIO_ADDR    = 4'h3;
    localparam logic [3:0] USB_CTRL_ADDR    = 4'h4;
    // oscillator control fields
    localparam int SWITCH_REQ_BIT  = 0;
    localparam int USB_FRC_EN_BIT  = 2;
    localparam int CLK_FAIL_BIT    = 3;
    localparam int USB_LOCK_BIT    = 6;
    localparam int CUR_SRC_LO      = 12;
    localparam int NEW_SRC_LO      = 8;
    localparam int BUS_DIV_LO      = 19;
    localparam int BUS_DIV_RDY_BIT = 21;
    // interrupt fields
    localparam int IRQ_BIT         = 14;
    localparam int PRIO_LO         = 10;
    localparam int SUBPRIO_LO      = 8;
    // usb control fields (usb_pll_enable, source select)
    localparam int USB_PLL_EN_BIT  = 0;
    localparam int USB_SRC_LO      = 1;
    // source codes
    localparam logic [2:0] SRC_FRC      = 3'h0;
    localparam logic [2:0] SRC_PRI      = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
    localparam logic [2:0] SRC_SEC      = 3'h4;
    localparam logic [1:0] CSM_BOTH     = 2'h0;
    localparam logic [1:0] CSM_SW_ONLY  = 2'h1;
    // usb clock source codes
    localparam logic [1:0] USB_SRC_FRC  = 2'h0;
    localparam logic [1:0] USB_SRC_PRI  = 2'h1;
    localparam logic [1:0] USB_SRC_PLL  = 2'h2;
    // timing
    localparam int CLK_HZ            = 50_000_000;
    localparam int DIV_SWITCH_CLOCKS = 60;
    localparam int USB_PLL_LOCK_STATUS_DELAY_US    = 2;
    localparam int USB_PLL_LOCK_STATUS_CYCLES      = (USB_PLL_LOCK_STATUS_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int MON_DELAY_US      = 40;
    localparam int MON_CYCLES        = (MON_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int CNT_W             = 12;
    localparam logic [31:0] OSC_CTRL_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        DS_IDLE = 3'b001,
        DS_WAIT = 3'b010,
        DS_SWAP = 3'b100
    } bcfsc_div_t;
endpackage
`default_nettype wire

// ### logic/bcfsc_bus_div.sv
// bcfsc_bus_div: divides the system clock into a bus clock enable and level
// assumes ratio changes only when its caller has checked the boundary flag
`default_nettype none
module bcfsc_bus_div (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // divide ratio as a power of two
    input  wire logic [1:0] ratio_log2,
    // outputs
    output logic            tick,
    output logic            level,
    output logic            boundary
);
    logic [2:0] cnt_reg;
    logic [2:0] limit;

    assign limit    = 3'((4'h1 << ratio_log2) - 4'h1);
    assign boundary = (cnt_reg == limit);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            tick    <= 1'b0;
            level   <= 1'b0;
        end else begin
            tick <= boundary;
            if (boundary) begin
                cnt_reg <= 3'h0;
            end else begin
                cnt_reg <= cnt_reg + 3'h1;
            end
            // low for the first half of each period; toggles at 1:1
            level <= (ratio_log2 == 2'h0) ? ~level : (cnt_reg > (limit >> 1));
        end
    end
endmodule
`default_nettype wire

// ### logic/bcfsc_top.sv
// bcfsc_top: bus clock divisor, usb clock path, two-speed start and fail-safe monitor
// assumes synchronous inputs on ref_clk and a single-cycle register port
//
// The implementer's own choices: strobed register access and the address map.
`default_nettype none
//
// Overview of operation
// - bus clock divides system clock by field
// - ratios one, two, four and eight
// - stall back-to-back bus accesses when divided
// - divisor change by machine, up to 60 clocks
// - writes during a change are dropped
// - ready bit shows switch in progress
// - rewriting same divisor starts nothing
// - usb clock from rc, primary or pll half
// - rc serves usb wake only; here usb_src_reg can select rc at any time
// - usb lock bit sets after delay
// - lock clear at reset and when unused
// - two-speed start runs rc then primary
// - two-speed start after reset or sleep
// - failure falls back to rc regardless
// - fallback loads source, sets flag, cancels switch
// - failure interrupt flag, enable, priorities
// - config code 01 switch only, 00 both
// - default source 010 primary, 011 with pll
// - monitor delay after reset release
// - delay expiry before start traps to rc
// - config bit one disables switch and monitor
module bcfsc_top #(
    parameter int USB_PLL_LOCK_STATUS_CNT = bcfsc_pkg::USB_PLL_LOCK_STATUS_CYCLES,
    parameter int MON_CNT   = bcfsc_pkg::MON_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // configuration words
    input  wire logic [1:0]  clock_switch_monitor_cfg,
    input  wire logic [2:0]  default_oscillator_cfg,
    // oscillator status
    input  wire logic        primary_ready,
    input  wire logic        primary_failed,
    input  wire logic        sleep_exit,
    input  wire logic        system_reset_n,
    // processor side
    input  wire logic        periph_access,
    output logic             cpu_stall,
    // clocks out
    output logic             periph_bus_clock,
    output logic             periph_bus_tick,
    output logic       [2:0] system_clock_source,
    output logic       [1:0] usb_clock_source,
    output logic             usb_fast_rc_on,
    output logic             clock_fail_irq
);
    import bcfsc_pkg::*;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    logic sw_enable;
    logic mon_enable;
    logic mon_mode;
    assign sw_enable  = (clock_switch_monitor_cfg[1] == 1'b0);
    assign mon_enable = (clock_switch_monitor_cfg == CSM_BOTH);
    assign mon_mode   = (default_oscillator_cfg == SRC_PRI) ||
                        (default_oscillator_cfg == SRC_PRI_PLL) ||
                        (default_oscillator_cfg == SRC_SEC);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [1:0]  div_reg;
    logic [1:0]  div_pend_reg;
    logic [1:0]  div_active_reg;
    bcfsc_div_t  dstate_reg;
    logic [5:0]  dcnt_reg;
    logic [2:0]  cur_src_reg;
    logic [2:0]  new_src_reg;
    logic        sw_req_reg;
    logic        usb_frc_reg;
    logic        cf_reg;
    logic        irq_flag_reg;
    logic        irq_en_reg;
    logic [2:0]  prio_reg;
    logic [1:0]  subprio_reg;
    logic        usb_pll_en_reg;
    logic [1:0]  usb_src_reg;
    logic        usb_pll_lock_status_reg;
    logic [CNT_W-1:0] usb_pll_lock_status_cnt_reg;
    logic [CNT_W-1:0] mon_cnt_reg;
    logic        mon_wait_reg;
    logic        started_reg;
    logic        bus_boundary;
    logic        fail_event;

    logic wr_osc;
    assign wr_osc = reg_wr && hit(reg_addr, OSC_CTRL_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // bus divisor state machine
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dstate_reg     <= DS_IDLE;
            div_reg        <= 2'h0;
            div_pend_reg   <= 2'h0;
            div_active_reg <= 2'h0;
            dcnt_reg       <= 6'h0;
        end else begin
            case (dstate_reg)
                DS_IDLE: begin
                    // same value ignored; busy writes never reach here
                    if (wr_osc && reg_wdata[BUS_DIV_LO +: 2] != div_reg) begin
                        div_pend_reg <= reg_wdata[BUS_DIV_LO +: 2];
                        dcnt_reg     <= 6'h0;
                        dstate_reg   <= DS_WAIT;
                    end
                end
                DS_WAIT: begin
                    dcnt_reg <= dcnt_reg + 6'h1;
                    // swap at a full bus period end to avoid a runt pulse
                    if (bus_boundary) begin
                        div_active_reg <= div_pend_reg;
                        dstate_reg     <= DS_SWAP;
                    end
                end
                DS_SWAP: begin
                    // settle time keeps total below the 60-clock limit
                    dcnt_reg <= dcnt_reg + 6'h1;
                    if (dcnt_reg >= 6'(DIV_SWITCH_CLOCKS - 2)) begin
                        div_reg    <= div_pend_reg;
                        dstate_reg <= DS_IDLE;
                    end
                end
                default: dstate_reg <= DS_IDLE;
            endcase
        end
    end

    bcfsc_bus_div u_div (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .ratio_log2 (div_active_reg),
        .tick       (periph_bus_tick),
        .level      (periph_bus_clock),
        .boundary   (bus_boundary)
    );

    // stall until the next bus tick while divided
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_stall <= 1'b0;
        end else if (div_active_reg == 2'h0) begin
            cpu_stall <= 1'b0;
        end else if (periph_access) begin
            cpu_stall <= 1'b1;
        end else if (bus_boundary) begin
            cpu_stall <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up, monitor delay and fail-safe fallback
    assign fail_event = mon_enable && started_reg &&
                        ((primary_failed && cur_src_reg != SRC_FRC) ||
                         (mon_wait_reg && mon_cnt_reg == 0 && !primary_ready));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            started_reg  <= 1'b0;
            mon_wait_reg <= 1'b0;
            mon_cnt_reg  <= '0;
            cur_src_reg  <= SRC_FRC;
        end else if (!system_reset_n || sleep_exit) begin
            // caught while system_reset_n is low, so the straps never feed the async reset
            started_reg  <= 1'b1;
            mon_wait_reg <= mon_enable && mon_mode;
            mon_cnt_reg  <= CNT_W'(MON_CNT);
            cur_src_reg  <= (mon_enable || sw_enable) && mon_mode ? SRC_FRC
                                                                  : default_oscillator_cfg;
        end else if (fail_event) begin
            cur_src_reg  <= SRC_FRC;
            mon_wait_reg <= 1'b0;
        end else begin
            if (mon_wait_reg && mon_cnt_reg != 0) begin
                mon_cnt_reg <= mon_cnt_reg - CNT_W'(1);
            end
            if (mon_wait_reg && primary_ready) begin
                mon_wait_reg <= 1'b0;
            end
            if (started_reg && sw_enable && cur_src_reg == SRC_FRC &&
                primary_ready && !cf_reg &&
                (default_oscillator_cfg == SRC_PRI || default_oscillator_cfg == SRC_PRI_PLL)) begin
                cur_src_reg <= default_oscillator_cfg;
            end else if (sw_req_reg && sw_enable) begin
                cur_src_reg <= new_src_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software bits; hardware set wins over software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sw_req_reg  <= 1'b0;
            new_src_reg <= 3'h0;
            usb_frc_reg <= 1'b0;
            cf_reg      <= 1'b0;
        end else begin
            if (wr_osc) begin
                new_src_reg <= reg_wdata[NEW_SRC_LO +: 3];
                usb_frc_reg <= reg_wdata[USB_FRC_EN_BIT];
            end
            if (fail_event || !sw_enable) begin
                sw_req_reg <= 1'b0;
            end else if (wr_osc) begin
                sw_req_reg <= reg_wdata[SWITCH_REQ_BIT];
            end else if (sw_req_reg) begin
                sw_req_reg <= 1'b0;
            end
            if (fail_event) begin
                cf_reg <= 1'b1;
            end else if (wr_osc || !system_reset_n) begin
                cf_reg <= system_reset_n && reg_wdata[CLK_FAIL_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_flag_reg <= 1'b0;
            irq_en_reg   <= 1'b0;
            prio_reg     <= 3'h0;
            subprio_reg  <= 2'h0;
        end else begin
            if (fail_event) begin
                irq_flag_reg <= 1'b1;
            end else if (reg_wr && hit(reg_addr, IRQ_FLAG_ADDR)) begin
                irq_flag_reg <= reg_wdata[IRQ_BIT];
            end
            if (reg_wr && hit(reg_addr, IRQ_EN_ADDR)) begin
                irq_en_reg <= reg_wdata[IRQ_BIT];
            end
            if (reg_wr && hit(reg_addr, IRQ_PRIO_ADDR)) begin
                prio_reg    <= reg_wdata[PRIO_LO +: 3];
                subprio_reg <= reg_wdata[SUBPRIO_LO +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // usb clock path and lock status
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            usb_pll_en_reg <= 1'b0;
            usb_src_reg    <= USB_SRC_PRI;
            usb_pll_lock_status_reg      <= 1'b0;
            usb_pll_lock_status_cnt_reg  <= '0;
        end else begin
            if (reg_wr && hit(reg_addr, USB_CTRL_ADDR)) begin
                usb_pll_en_reg <= reg_wdata[USB_PLL_EN_BIT];
                usb_src_reg    <= reg_wdata[USB_SRC_LO +: 2];
            end
            if (!usb_pll_en_reg || usb_src_reg != USB_SRC_PLL) begin
                usb_pll_lock_status_reg     <= 1'b0;
                usb_pll_lock_status_cnt_reg <= '0;
            end else if (usb_pll_lock_status_cnt_reg == CNT_W'(USB_PLL_LOCK_STATUS_CNT)) begin
                usb_pll_lock_status_reg     <= 1'b1;
            end else begin
                usb_pll_lock_status_cnt_reg <= usb_pll_lock_status_cnt_reg + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_clock_source <= SRC_FRC;
            usb_clock_source    <= USB_SRC_PRI;
            usb_fast_rc_on      <= 1'b0;
            clock_fail_irq      <= 1'b0;
        end else begin
            system_clock_source <= cur_src_reg;
            // rc whenever usb_src_reg selects it; no suspend gating
            usb_clock_source    <= usb_src_reg;
            usb_fast_rc_on      <= usb_frc_reg;
            clock_fail_irq      <= irq_flag_reg && irq_en_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0;
            if (hit(reg_addr, OSC_CTRL_ADDR)) begin
                reg_rdata[SWITCH_REQ_BIT]       <= sw_req_reg;
                reg_rdata[USB_FRC_EN_BIT]       <= usb_frc_reg;
                reg_rdata[CLK_FAIL_BIT]         <= cf_reg;
                reg_rdata[USB_LOCK_BIT]         <= usb_pll_lock_status_reg;
                reg_rdata[NEW_SRC_LO +: 3]      <= new_src_reg;
                reg_rdata[CUR_SRC_LO +: 3]      <= cur_src_reg;
                reg_rdata[BUS_DIV_LO +: 2]      <= div_reg;
                reg_rdata[BUS_DIV_RDY_BIT]      <= (dstate_reg == DS_IDLE);
            end else if (hit(reg_addr, IRQ_FLAG_ADDR)) begin
                reg_rdata[IRQ_BIT] <= irq_flag_reg;
            end else if (hit(reg_addr, IRQ_EN_ADDR)) begin
                reg_rdata[IRQ_BIT] <= irq_en_reg;
            end else if (hit(reg_addr, IRQ_PRIO_ADDR)) begin
                reg_rdata[PRIO_LO +: 3]    <= prio_reg;
                reg_rdata[SUBPRIO_LO +: 2] <= subprio_reg;
            end else if (hit(reg_addr, USB_CTRL_ADDR)) begin
                reg_rdata[USB_PLL_EN_BIT]  <= usb_pll_en_reg;
                reg_rdata[USB_SRC_LO +: 2] <= usb_src_reg;
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// ### verif/bcfsc_checker.sv
// bcfsc_checker: port-level checks for bcfsc_top
// assumes straps change only while system_reset_n is held low
`default_nettype none
module bcfsc_checker #(
    parameter int USB_PLL_LOCK_STATUS_CNT = 4,
    parameter int MON_CNT   = 8
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // straps and oscillator status
    input wire logic [1:0] clock_switch_monitor_cfg,
    input wire logic       primary_ready,
    input wire logic       primary_failed,
    input wire logic       system_reset_n,
    // processor and register side
    input wire logic       reg_wr,
    input wire logic       periph_access,
    input wire logic       cpu_stall,
    // clocks out
    input wire logic       periph_bus_tick,
    input wire logic [2:0] system_clock_source,
    input wire logic [1:0] usb_clock_source
);
    import bcfsc_pkg::*;
    logic [4:0] stall_cnt;
    logic [3:0] gap_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // saturating counters, so a stuck output cannot wrap back into range
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stall_cnt <= 5'h00;
        end else if (!cpu_stall) begin
            stall_cnt <= 5'h00;
        end else if (stall_cnt != 5'h1F) begin
            stall_cnt <= stall_cnt + 5'h01;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst || periph_bus_tick) begin
            gap_cnt <= 4'h0;
        end else if (gap_cnt != 4'hF) begin
            gap_cnt <= gap_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_stall_cause: assert property ($rose(cpu_stall) |->
        $past(periph_access) || $past(periph_access, 2)) else $error("stall without access");
    chk_stall_bound: assert property (stall_cnt < 5'h18)
        else $error("stall too long");
    chk_tick_gap: assert property (gap_cnt <= 4'h8)
        else $error("bus tick gap above eight");
    chk_fail_fallback: assert property ((system_reset_n && primary_failed
        && clock_switch_monitor_cfg == CSM_BOTH && system_clock_source != SRC_FRC)
        |-> ##2 system_clock_source == SRC_FRC) else $error("no fallback on failure");
    chk_fail_stays: assert property ((system_reset_n && primary_failed && !reg_wr
        && clock_switch_monitor_cfg == CSM_BOTH && system_clock_source == SRC_FRC)
        |=> system_clock_source == SRC_FRC) else $error("left rc after failure");
    chk_no_switch_cfg: assert property ((clock_switch_monitor_cfg[1] && system_reset_n
        && $past(system_reset_n, 2) && $past(system_reset_n, 4))
        |-> $stable(system_clock_source)) else $error("source moved with switching off");
    chk_two_speed: assert property ((!clock_switch_monitor_cfg[1]
        && system_clock_source == SRC_PRI && $past(system_clock_source) == SRC_FRC)
        |-> $past(primary_ready)) else $error("primary taken before ready");
    chk_usb_src: assert property (usb_clock_source != 2'h3)
        else $error("illegal usb clock source");
endmodule
bind bcfsc_top bcfsc_checker #(.USB_PLL_LOCK_STATUS_CNT(USB_PLL_LOCK_STATUS_CNT), .MON_CNT(MON_CNT)) u_chk (.*);
`default_nettype wire

// ### verif/bcfsc_osc_model.sv
// bcfsc_osc_model: primary oscillator with a start-up delay and a failure switch
// assumes the bench sets start_cycles while system_reset_n is low
`default_nettype none
module bcfsc_osc_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // control from the bench
    input  wire logic       system_reset_n,
    input  wire logic [7:0] start_cycles,
    input  wire logic       fail_cmd,
    // oscillator status
    output logic            primary_ready,
    output logic            primary_failed
);
    logic [7:0] run_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_cnt        <= 8'h00;
            primary_ready  <= 1'b0;
            primary_failed <= 1'b0;
        end else begin
            // start count restarts on every internal reset, as a crystal would
            run_cnt <= !system_reset_n ? 8'h00 : (run_cnt == 8'hFF ? run_cnt : run_cnt + 8'h01);
            // zero start_cycles models an oscillator that never starts
            primary_ready  <= system_reset_n && start_cycles != 8'h00
                && run_cnt >= start_cycles && !fail_cmd;
            primary_failed <= fail_cmd;
        end
    end
endmodule
`default_nettype wire

// ### verif/bcfsc_top_bench.sv
// bcfsc_top_bench: directed tests of bcfsc_top against the oscillator model
// assumes short lock and monitor counts of 4 and 8 cycles
`default_nettype none
module bcfsc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import bcfsc_pkg::*;
    logic        ref_clk, rst, reg_wr, reg_rd, sleep_exit, system_reset_n, fail_cmd;
    logic        periph_access, primary_ready, primary_failed, cpu_stall, periph_bus_clock;
    logic        periph_bus_tick, usb_fast_rc_on, clock_fail_irq, seen;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [1:0]  clock_switch_monitor_cfg, usb_clock_source;
    logic [2:0]  default_oscillator_cfg, system_clock_source;
    logic [7:0]  start_cycles;
    int          error_cnt, n_checks;
    bcfsc_top #(.USB_PLL_LOCK_STATUS_CNT(4), .MON_CNT(8)) dut (.*);
    bcfsc_osc_model u_osc (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic boot(input logic [1:0] c, input logic [2:0] s, input logic [7:0] st);
        @(posedge ref_clk);
        fail_cmd <= 1'b0;
        repeat (3) @(posedge ref_clk);
        {system_reset_n, clock_switch_monitor_cfg, default_oscillator_cfg} <= {1'b0, c, s};
        start_cycles <= st;
        repeat (2) @(posedge ref_clk);
        system_reset_n <= 1'b1;
    endtask
    task automatic set_fail(input logic f, input int n);
        @(posedge ref_clk);
        fail_cmd <= f;
        cyc(n);
    endtask
    task automatic burst();
        @(posedge ref_clk);
        periph_access <= 1'b1;
        repeat (2) @(posedge ref_clk);
        periph_access <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            #1 seen = seen | cpu_stall;
            @(posedge ref_clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // second write lands while busy, so every change also proves the drop
    task automatic div_set(input logic [1:0] v);
        int i;
        int g;
        wr(OSC_CTRL_ADDR, 32'(v) << BUS_DIV_LO);
        wr(OSC_CTRL_ADDR, 32'(v ^ 2'h1) << BUS_DIV_LO);
        rd(OSC_CTRL_ADDR);
        chk(d[BUS_DIV_RDY_BIT], 1'b0, "ready during switch");
        i = 0;
        while (d[BUS_DIV_RDY_BIT] !== 1'b1 && i < 29) begin
            rd(OSC_CTRL_ADDR);
            i++;
        end
        chk(d[BUS_DIV_RDY_BIT], 1'b1, "switch too long");
        chk(d[20:19], v, "divisor field");
        i = 0;
        do begin
            cyc(1);
        end while (periph_bus_tick !== 1'b1);
        g = 0;
        do begin
            cyc(1);
            g++;
            i += periph_bus_clock;
        end while (periph_bus_tick !== 1'b1 && g < 16);
        chk(g, 1 << v, "bus tick spacing");
        if (v != 0) chk(i, g / 2, "bus clock duty");
    endtask
    task automatic test_div();
        div_set(2'h1);
        div_set(2'h2);
        div_set(2'h0);
        div_set(2'h3);
        wr(OSC_CTRL_ADDR, 32'h0018_0000);
        rd(OSC_CTRL_ADDR);
        chk(d[BUS_DIV_RDY_BIT], 1'b1, "same divisor started switch");
        burst();
        chk(seen, 1'b1, "no stall when divided");
        div_set(2'h0);
        burst();
        chk(seen, 1'b0, "stall at full rate");
        $display("done: divisor");
    endtask
    task automatic test_usb();
        wr(USB_CTRL_ADDR, 32'h0000_0005);
        rd(OSC_CTRL_ADDR);
        chk(d[USB_LOCK_BIT], 1'b0, "lock too early");
        cyc(8);
        rd(OSC_CTRL_ADDR);
        chk(d[USB_LOCK_BIT], 1'b1, "lock missing");
        chk(usb_clock_source, USB_SRC_PLL, "usb pll source");
        wr(USB_CTRL_ADDR, 32'h0000_0003);
        rd(OSC_CTRL_ADDR);
        chk(d[USB_LOCK_BIT], 1'b0, "lock without pll");
        chk(usb_clock_source, USB_SRC_PRI, "usb primary source");
        wr(USB_CTRL_ADDR, 32'h0000_0000);
        wr(OSC_CTRL_ADDR, 32'h0000_0004);
        cyc(2);
        chk(usb_clock_source, USB_SRC_FRC, "usb rc source");
        chk(usb_fast_rc_on, 1'b1, "usb rc enable");
        $display("done: usb");
    endtask
    task automatic test_monitor();
        boot(CSM_BOTH, SRC_PRI, 8'h00);
        rd(OSC_CTRL_ADDR);
        chk(d[CLK_FAIL_BIT], 1'b0, "trap inside delay");
        cyc(12);
        rd(OSC_CTRL_ADDR);
        chk(d[CLK_FAIL_BIT], 1'b1, "no trap on slow start");
        chk(d[14:12], SRC_FRC, "source after trap");
        $display("done: monitor delay");
    endtask
    task automatic test_fail();
        boot(CSM_BOTH, SRC_PRI, 8'h02);
        cyc(1);
        chk(system_clock_source, SRC_FRC, "two-speed start");
        cyc(14);
        chk(system_clock_source, SRC_PRI, "primary after start");
        wr(IRQ_FLAG_ADDR, 32'h0000_0000);
        set_fail(1'b1, 3);
        chk(system_clock_source, SRC_FRC, "fallback");
        rd(OSC_CTRL_ADDR);
        chk({d[14:12], d[CLK_FAIL_BIT], d[SWITCH_REQ_BIT]}, 5'h02, "fallback fields");
        rd(IRQ_FLAG_ADDR);
        chk(d[IRQ_BIT], 1'b1, "fail flag");
        chk(clock_fail_irq, 1'b0, "irq while disabled");
        wr(IRQ_EN_ADDR, 32'h0000_4000);
        cyc(2);
        chk(clock_fail_irq, 1'b1, "irq enabled");
        wr(IRQ_PRIO_ADDR, 32'h0000_1600);
        rd(IRQ_PRIO_ADDR);
        chk(d[12:8], 5'h16, "priority fields");
        set_fail(1'b0, 10);
        chk(system_clock_source, SRC_FRC, "stays on rc");
        $display("done: fail-safe");
    endtask
    task automatic test_cfg();
        boot(2'h2, SRC_PRI, 8'h00);
        cyc(12);
        chk(system_clock_source, SRC_PRI, "strap source");
        set_fail(1'b1, 4);
        chk(system_clock_source, SRC_PRI, "monitor off");
        boot(CSM_SW_ONLY, SRC_PRI_PLL, 8'h02);
        cyc(12);
        chk(system_clock_source, SRC_PRI_PLL, "primary with pll");
        set_fail(1'b1, 4);
        chk(system_clock_source, SRC_PRI_PLL, "switch only mode");
        $display("done: configuration");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #400000;
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        report_and_stop();
    end
    initial begin
        {rst, reg_wr, reg_rd, sleep_exit, system_reset_n, fail_cmd, periph_access} = 7'h40;
        {reg_addr, reg_wdata, start_cycles} = '0;
        {clock_switch_monitor_cfg, default_oscillator_cfg} = 5'h10;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        test_div();
        test_usb();
        test_monitor();
        test_fail();
        test_cfg();
        report_and_stop();
    end
endmodule
`default_nettype wire
